// ---- hw/rtcsl_consts.svh ----
`ifndef RTCSL_CONSTS_SVH
`define RTCSL_CONSTS_SVH

// Control byte layout
`define RTCSL_CODE_MSB        7
`define RTCSL_CODE_LSB        4
`define RTCSL_CS_MSB          3
`define RTCSL_CS_LSB          1
`define RTCSL_RW_BIT          0
`define RTCSL_CODE_EEPROM     4'ha
`define RTCSL_CODE_RTCC       4'hd
`define RTCSL_CS_VALUE        3'h7

// Implemented byte addresses per space
`define RTCSL_RTCC_LAST       8'h5f
`define RTCSL_EE_LAST         8'h7f
`define RTCSL_EE_PROT_FIRST   8'hf0
`define RTCSL_EE_PROT_LAST    8'hf7
`define RTCSL_EE_STATUS       8'hff

// Byte framing
`define RTCSL_BITS_PER_BYTE   4'h8
`define RTCSL_BIT_CNT_ZERO    4'h0
`define RTCSL_BIT_CNT_ONE     4'h1
`define RTCSL_ADDR_STEP       8'h01

// Reset values
`define RTCSL_LINE_IDLE       1'b1
`define RTCSL_BYTE_RESET      8'h00

`endif

// ---- hw/rtcsl_mfp_out.sv ----
`timescale 1ns/1ps

module rtcsl_mfp_out (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Function selection and levels
  input  wire logic alarmSel,
  input  wire logic alarmLevel,
  input  wire logic sqwSel,
  input  wire logic sqwLevel,
  input  wire logic gpOutBit,
  // Open-drain pin
  output logic      pinOut,
  output logic      pinOe
);

  logic level;

  // Square wave wins over alarm, general output otherwise
  always_comb begin
    if (sqwSel) begin
      level = sqwLevel;
    end else if (alarmSel) begin
      level = alarmLevel;
    end else begin
      level = gpOutBit;
    end
  end

  assign pinOut = 1'b0;

  // Open drain: only ever pull low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pinOe <= 1'b0;
    end else begin
      pinOe <= ~level;
    end
  end

endmodule : rtcsl_mfp_out

// ---- hw/rtcsl_pkg.sv ----
package rtcsl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } rtcsl_state_type;

  typedef enum logic [1:0] {
    SP_NONE,
    SP_EEPROM,
    SP_RTCC
  } rtcsl_space_type;

endpackage : rtcsl_pkg

// ---- hw/rtcsl_sync.sv ----
`timescale 1ns/1ps

module rtcsl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Asynchronous level in, synchronised level out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1_reg <= RESET_VAL;
      syncOut    <= RESET_VAL;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule : rtcsl_sync

// ---- hw/rtcsl_two_wire_slave.sv ----
// What this block does
// R1 - Detect Start when data falls while clock is high.
// R2 - Detect Stop when data rises while clock is high.
// R3 - Master opens each command with Start and ends each with Stop.
// R4 - Data changes only while clock is low; one bit per clock pulse.
// R5 - Master starts transfers only with both lines idle high.
// R6 - Master alone decides byte count between Start and Stop.
// R7 - Acknowledge by holding data low through the acknowledge clock high phase.
// R8 - Master gives a ninth clock pulse per byte for the acknowledge.
// R9 - No acknowledge for EEPROM control byte while programming; RTCC space still served.
// R10 - Ignore all bus activity while running from backup supply.
// R11 - Master marks last read byte by not acknowledging it.
// R12 - After unacknowledged read byte, release data high for Stop.
// R13 - First byte after Start is control; code 1010 EEPROM, 1101 RTCC/SRAM.
// R14 - Three chip-select bits must be ones to match.
// R15 - Control byte bit zero: one is read, zero is write.
// R16 - Valid slave address is acknowledged, then read or write follows.
// R17 - Multifunction pin: alarm, square wave, or open-drain general output.
// R18 - Withhold acknowledge for byte addresses outside the selected space.
// R19 - Unmatched control byte is not acknowledged; idle until next Start.
`include "rtcsl_consts.svh"
`timescale 1ns/1ps

module rtcsl_two_wire_slave (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // Serial bus pins
  input  wire logic                      sclIn,
  input  wire logic                      sdaIn,
  output logic                           sdaOut,
  output logic                           sdaOe,
  // Power and EEPROM status
  input  wire logic                      onBackup,
  input  wire logic                      eepromBusy,
  // Memory side
  output rtcsl_pkg::rtcsl_space_type     spaceSel,
  output logic                           readOp,
  output logic                           busActive,
  output logic [7:0]                     readAddr,
  input  wire logic [7:0]                readData,
  output logic                           readStrobe,
  output logic [7:0]                     writeAddr,
  output logic [7:0]                     writeData,
  output logic                           writeStrobe,
  // Multifunction pin control
  input  wire logic                      alarmSel,
  input  wire logic                      alarmLevel,
  input  wire logic                      sqwSel,
  input  wire logic                      sqwLevel,
  input  wire logic                      gpOutBit,
  // Multifunction pin
  output logic                           multifunction_pinOut,
  output logic                           multifunction_pinOe
);

  import rtcsl_pkg::*;

  logic            sclSync;
  logic            sdaSync;
  logic            backupSync;
  logic            sclPrev_reg;
  logic            sdaPrev_reg;
  logic            startEv;
  logic            stopEv;
  logic            riseEv;
  logic            fallEv;
  logic            byteDone;
  logic            ackEnd;
  logic            loadTx;
  logic            ackGive;
  logic            csOk;
  logic            hitRtcc;
  logic            hitEe;
  logic            inByte;
  rtcsl_state_type state_reg;
  rtcsl_space_type space_reg;
  logic [3:0]      bitCnt_reg;
  logic            ackPhase_reg;
  logic            masterAck_reg;
  logic [7:0]      rxByte_reg;
  logic [7:0]      txByte_reg;
  logic            sdaPull_reg;
  logic            readOp_reg;
  logic [7:0]      addr_reg;
  logic [7:0]      addr_next;

  // Pins cross into the system clock
  rtcsl_sync #(.RESET_VAL(`RTCSL_LINE_IDLE)) u_sync_scl (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn (sclIn),
    .syncOut (sclSync)
  );

  rtcsl_sync #(.RESET_VAL(`RTCSL_LINE_IDLE)) u_sync_sda (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn (sdaIn),
    .syncOut (sdaSync)
  );

  rtcsl_sync #(.RESET_VAL(1'b0)) u_sync_backup (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn (onBackup),
    .syncOut (backupSync)
  );

  // Line history for edge and condition detection
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclPrev_reg <= `RTCSL_LINE_IDLE;
      sdaPrev_reg <= `RTCSL_LINE_IDLE;
    end else begin
      sclPrev_reg <= sclSync;
      sdaPrev_reg <= sdaSync;
    end
  end

  assign startEv = sclSync & sclPrev_reg & sdaPrev_reg & ~sdaSync;   // [R1]
  assign stopEv  = sclSync & sclPrev_reg & ~sdaPrev_reg & sdaSync;   // [R2]
  assign riseEv  = sclSync & ~sclPrev_reg;
  assign fallEv  = ~sclSync & sclPrev_reg;

  // Ninth pulse is the acknowledge slot
  assign inByte   = (state_reg != ST_IDLE) && (state_reg != ST_IGNORE)
                    && (bitCnt_reg < `RTCSL_BITS_PER_BYTE) && !ackPhase_reg;
  assign byteDone = fallEv && (bitCnt_reg == `RTCSL_BITS_PER_BYTE) && !ackPhase_reg
                    && (state_reg != ST_IDLE) && (state_reg != ST_IGNORE);   // [R8]
  assign ackEnd   = fallEv && ackPhase_reg;

  // Control byte decode
  assign csOk    = rxByte_reg[`RTCSL_CS_MSB:`RTCSL_CS_LSB] == `RTCSL_CS_VALUE;   // [R14]
  assign hitRtcc = rxByte_reg[`RTCSL_CODE_MSB:`RTCSL_CODE_LSB] == `RTCSL_CODE_RTCC;   // [R13]
  assign hitEe   = rxByte_reg[`RTCSL_CODE_MSB:`RTCSL_CODE_LSB] == `RTCSL_CODE_EEPROM;   // [R13]

  function automatic logic addrInSpace(input rtcsl_space_type sp, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (sp == SP_RTCC) begin
      ok = a <= `RTCSL_RTCC_LAST;
    end else if (sp == SP_EEPROM) begin
      ok = (a <= `RTCSL_EE_LAST) || (a == `RTCSL_EE_STATUS)
           || ((a >= `RTCSL_EE_PROT_FIRST) && (a <= `RTCSL_EE_PROT_LAST));
    end
    return ok;
  endfunction : addrInSpace

  // Whether the byte just received earns an acknowledge
  always_comb begin
    ackGive = 1'b0;
    unique case (state_reg)
      ST_CTRL: begin
        ackGive = csOk && (hitRtcc || (hitEe && !eepromBusy));   // [R9] [R16] [R19]
      end
      ST_ADDR: begin
        ackGive = addrInSpace(space_reg, rxByte_reg);   // [R18]
      end
      ST_WDATA: begin
        ackGive = 1'b1;
      end
      ST_IDLE, ST_RDATA, ST_IGNORE: begin
        ackGive = 1'b0;
      end
    endcase
  end

  // A read byte is fetched after the control byte or a master acknowledge
  assign loadTx = ackEnd && (((state_reg == ST_CTRL) && readOp_reg)
                  || ((state_reg == ST_RDATA) && masterAck_reg));

  // Protocol state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      bitCnt_reg   <= `RTCSL_BIT_CNT_ZERO;
      ackPhase_reg <= 1'b0;
    end else if (backupSync) begin
      state_reg    <= ST_IDLE;   // [R10]
      bitCnt_reg   <= `RTCSL_BIT_CNT_ZERO;
      ackPhase_reg <= 1'b0;
    end else if (startEv) begin
      state_reg    <= ST_CTRL;   // [R1] [R13]
      bitCnt_reg   <= `RTCSL_BIT_CNT_ZERO;
      ackPhase_reg <= 1'b0;
    end else if (stopEv) begin
      state_reg    <= ST_IDLE;   // [R2]
      bitCnt_reg   <= `RTCSL_BIT_CNT_ZERO;
      ackPhase_reg <= 1'b0;
    end else if (riseEv && inByte) begin
      bitCnt_reg <= bitCnt_reg + `RTCSL_BIT_CNT_ONE;   // [R4]
    end else if (byteDone) begin
      if ((state_reg == ST_RDATA) || ackGive) begin
        ackPhase_reg <= 1'b1;
      end else begin
        state_reg  <= ST_IGNORE;   // [R19] [R18]
        bitCnt_reg <= `RTCSL_BIT_CNT_ZERO;
      end
    end else if (ackEnd) begin
      ackPhase_reg <= 1'b0;
      bitCnt_reg   <= `RTCSL_BIT_CNT_ZERO;
      unique case (state_reg)
        ST_CTRL: begin
          state_reg <= readOp_reg ? ST_RDATA : ST_ADDR;   // [R15] [R16]
        end
        ST_ADDR, ST_WDATA: begin
          state_reg <= ST_WDATA;
        end
        ST_RDATA: begin
          state_reg <= masterAck_reg ? ST_RDATA : ST_IGNORE;   // [R11]
        end
        ST_IDLE, ST_IGNORE: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // Receive shifter and master acknowledge sample
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxByte_reg    <= `RTCSL_BYTE_RESET;
      masterAck_reg <= 1'b0;
    end else if (riseEv && inByte) begin
      rxByte_reg <= {rxByte_reg[6:0], sdaSync};   // [R4]
    end else if (riseEv && ackPhase_reg && (state_reg == ST_RDATA)) begin
      masterAck_reg <= ~sdaSync;   // [R11]
    end
  end

  // Control byte results
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      space_reg  <= SP_NONE;
      readOp_reg <= 1'b0;
    end else if (byteDone && (state_reg == ST_CTRL) && ackGive) begin
      space_reg  <= hitEe ? SP_EEPROM : SP_RTCC;   // [R13]
      readOp_reg <= rxByte_reg[`RTCSL_RW_BIT];   // [R15]
    end
  end

  // Data line drive, changed on clock falls and cleared on Start, Stop or backup
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sdaPull_reg <= 1'b0;
      txByte_reg  <= `RTCSL_BYTE_RESET;
    end else if (backupSync || startEv || stopEv) begin
      sdaPull_reg <= 1'b0;   // [R10]
    end else if (byteDone) begin
      sdaPull_reg <= (state_reg != ST_RDATA) && ackGive;   // [R7]
    end else if (loadTx) begin
      sdaPull_reg <= ~readData[7];   // [R4]
      txByte_reg  <= {readData[6:0], 1'b0};
    end else if (ackEnd) begin
      sdaPull_reg <= 1'b0;   // [R12]
    end else if (fallEv && (state_reg == ST_RDATA) && !ackPhase_reg
                 && (bitCnt_reg != `RTCSL_BIT_CNT_ZERO)) begin
      sdaPull_reg <= ~txByte_reg[7];   // [R4]
      txByte_reg  <= {txByte_reg[6:0], 1'b0};
    end
  end

  // Byte address pointer
  always_comb begin
    addr_next = addr_reg;
    if (ackEnd && (state_reg == ST_ADDR)) begin
      addr_next = rxByte_reg;
    end else if ((ackEnd && (state_reg == ST_WDATA))
                 || (byteDone && (state_reg == ST_RDATA))) begin
      addr_next = addr_reg + `RTCSL_ADDR_STEP;
    end
  end

  // Pointer survives a repeated Start so a read can follow the address write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_reg <= `RTCSL_BYTE_RESET;
    end else if (!backupSync) begin
      addr_reg <= addr_next;
    end
  end

  // Memory side strobes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      writeStrobe <= 1'b0;
      writeAddr   <= `RTCSL_BYTE_RESET;
      writeData   <= `RTCSL_BYTE_RESET;
      readStrobe  <= 1'b0;
    end else begin
      writeStrobe <= ackEnd && (state_reg == ST_WDATA) && !backupSync;
      readStrobe  <= loadTx && !backupSync;
      if (ackEnd && (state_reg == ST_WDATA)) begin
        writeAddr <= addr_reg;
        writeData <= rxByte_reg;
      end
    end
  end

  // Open drain: only ever pull low
  assign sdaOut    = 1'b0;
  assign sdaOe     = sdaPull_reg;
  assign spaceSel  = space_reg;
  assign readOp    = readOp_reg;
  assign readAddr  = addr_reg;
  assign busActive = (state_reg != ST_IDLE) && (state_reg != ST_IGNORE);

  rtcsl_mfp_out u_mfp (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .alarmSel   (alarmSel),
    .alarmLevel (alarmLevel),
    .sqwSel     (sqwSel),
    .sqwLevel   (sqwLevel),
    .gpOutBit   (gpOutBit),
    .pinOut     (multifunction_pinOut),
    .pinOe      (multifunction_pinOe)
  );   // [R17]

endmodule : rtcsl_two_wire_slave

// ---- testbench/rtcsl_i2c_master.sv ----
`timescale 1ns/1ps

module rtcsl_i2c_master (
  // Clock and resolved data line
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  // Master pins
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // Also a repeated start: data rises first while clock is low
  task automatic start();
    sda <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask : start
  task automatic bitx(input logic b, output logic r);
    sda <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sdaLine;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask : bitx
  // Caller picks how many bytes go between start and stop
  task automatic xbyte(input logic [7:0] b, input logic ackIn, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r[i]);
    end
    bitx(ackIn, ack);
  endtask : xbyte
  task automatic stop();
    sda <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda <= 1'b1;
    tick(4);
  endtask : stop
endmodule : rtcsl_i2c_master

// ---- testbench/rtcsl_two_wire_slave_props.sv ----
`timescale 1ns/1ps

module rtcsl_two_wire_slave_props (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  // Bus and power
  input wire logic                 sclIn,
  input wire logic                 sdaIn,
  input wire logic                 sdaOe,
  input wire logic                 onBackup,
  input wire logic                 eepromBusy,
  // Memory side
  input rtcsl_pkg::rtcsl_space_type spaceSel,
  input wire logic                 readOp,
  input wire logic                 busActive,
  input wire logic                 readStrobe,
  input wire logic                 writeStrobe,
  // Multifunction pin
  input wire logic                 alarmSel,
  input wire logic                 alarmLevel,
  input wire logic                 sqwSel,
  input wire logic                 sqwLevel,
  input wire logic                 gpOutBit,
  input wire logic                 multifunction_pinOe
);
  import rtcsl_pkg::*;
  logic mfpLevel;
  assign mfpLevel = sqwSel ? sqwLevel : (alarmSel ? alarmLevel : gpOutBit);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Backup switch-over may land mid-high, so it is excluded
  property p_oe_scl_low;
    $changed(sdaOe) && !onBackup && !$past(onBackup, 4) |-> !sclIn;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("Data drive changed with clock high");
  property p_backup_quiet;
    onBackup [*5] |-> !sdaOe && !busActive && !writeStrobe && !readStrobe;
  endproperty
  a_backup_quiet: assert property (p_backup_quiet) else $error("Bus activity on backup");
  property p_start_seen;
    sclIn && $fell(sdaIn) && !onBackup |-> ##[1:4] busActive;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("Start not seen");
  property p_stop_seen;
    sclIn && $rose(sdaIn) |-> ##[1:4] !busActive;
  endproperty
  a_stop_seen: assert property (p_stop_seen) else $error("Stop not seen");
  property p_ee_busy;
    spaceSel == SP_EEPROM && $past(spaceSel) != SP_EEPROM |-> !eepromBusy;
  endproperty
  a_ee_busy: assert property (p_ee_busy) else $error("EEPROM selected while busy");
  property p_write_dir;
    writeStrobe |-> !readOp && busActive && spaceSel != SP_NONE ##1 !writeStrobe;
  endproperty
  a_write_dir: assert property (p_write_dir) else $error("Write strobe out of a write");
  property p_read_dir;
    readStrobe |-> readOp && busActive ##1 !readStrobe;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("Read strobe out of a read");
  property p_mfp;
    !$past(sys_rst) |-> multifunction_pinOe == !$past(mfpLevel);
  endproperty
  a_mfp: assert property (p_mfp) else $error("Multifunction pin level wrong");
endmodule : rtcsl_two_wire_slave_props

bind rtcsl_two_wire_slave rtcsl_two_wire_slave_props u_props (.clk_sys, .sys_rst, .sclIn, .sdaIn, .sdaOe,
  .onBackup, .eepromBusy, .spaceSel, .readOp, .busActive, .readStrobe, .writeStrobe, .alarmSel, .alarmLevel,
  .sqwSel, .sqwLevel, .gpOutBit, .multifunction_pinOe);

// ---- testbench/rtcsl_two_wire_slave_tb.sv ----
`timescale 1ns/1ps

module rtcsl_two_wire_slave_tb;
  import rtcsl_pkg::*;
  logic            clk_sys = 1'b0;
  logic            sys_rst = 1'b1;
  logic            onBackup = 1'b0;
  logic            eepromBusy = 1'b0;
  logic [4:0]      mfpIn = 5'h00;
  logic            mScl, mSda, sdaOut, sdaOe, readOp, busActive, readStrobe, writeStrobe, mfpOut, mfpOe;
  rtcsl_space_type spaceSel;
  logic [7:0]      readAddr, writeAddr, writeData;
  logic [7:0]      mem [256];
  logic [7:0]      shadow [256];
  logic [15:0]     wq [$];
  logic [15:0]     wExp;
  logic [7:0]      rq [$];
  logic [7:0]      rExp;
  int              n_errors = 0;
  int              compares = 0;
  // Pull-up: line is low whenever either side pulls
  wire             sdaLine = mSda & ~sdaOe;
  wire [7:0]       readData = mem[readAddr];
  always #25 clk_sys = ~clk_sys;
  rtcsl_i2c_master MST (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(mScl), .sda(mSda));
  rtcsl_two_wire_slave DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(mScl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .onBackup(onBackup), .eepromBusy(eepromBusy), .spaceSel(spaceSel),
    .readOp(readOp), .busActive(busActive), .readAddr(readAddr), .readData(readData), .readStrobe(readStrobe),
    .writeAddr(writeAddr), .writeData(writeData), .writeStrobe(writeStrobe), .alarmSel(mfpIn[2]),
    .alarmLevel(mfpIn[1]), .sqwSel(mfpIn[4]), .sqwLevel(mfpIn[3]), .gpOutBit(mfpIn[0]),
    .multifunction_pinOut(mfpOut), .multifunction_pinOe(mfpOe));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic txb(input logic [7:0] b, input logic nak);
    logic [7:0] r;
    logic       a;
    MST.xbyte(b, 1'b1, r, a);
    chk("ack", {7'h0, nak}, {7'h0, a});
  endtask : txb
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Write monitor doubles as the memory behind the block
  always @(posedge clk_sys) begin
    if (writeStrobe === 1'b1) begin
      wExp = (wq.size() > 0) ? wq.pop_front() : 16'hxxxx;
      chk("writeAddr", wExp[15:8], writeAddr);
      chk("writeData", wExp[7:0], writeData);
      mem[writeAddr] <= writeData;
    end
    if (readStrobe === 1'b1) begin
      rExp = (rq.size() > 0) ? rq.pop_front() : 8'hxx;
      chk("readAddr", rExp, readAddr);
    end
  end
  initial begin
    #2_000_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [7:0]  a, d, r;
    logic        k;
    logic [31:0] tbl [14];
    void'($urandom(32'h3489));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      shadow[i] = mem[i];
    end
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    a = 8'($urandom_range(0, 94));
    MST.start();
    chk("busActive", 8'h01, {7'h0, busActive});
    txb(8'hde, 1'b0);
    txb(a, 1'b0);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      wq.push_back({a + 8'(i), d});
      shadow[a + 8'(i)] = d;
      txb(d, 1'b0);
    end
    MST.stop();
    chk("spaceSel", 8'(SP_RTCC), 8'(spaceSel));
    chk("busActive", 8'h00, {7'h0, busActive});
    // Random read: pointer set by a write, then repeated start
    MST.start();
    txb(8'hde, 1'b0);
    txb(a, 1'b0);
    MST.start();
    rq.push_back(a);
    rq.push_back(a + 8'h01);
    txb(8'hdf, 1'b0);
    chk("readOp", 8'h01, {7'h0, readOp});
    for (int i = 0; i < 2; i++) begin
      MST.xbyte(8'hff, i[0], r, k);
      chk("readData", shadow[a + 8'(i)], r);
    end
    MST.tick(3);
    chk("sdaLine", 8'h01, {7'h0, sdaLine});
    chk("readAddr", a + 8'h02, readAddr);
    MST.stop();
    // ctrl, addr, backup, busy, ctrl nak, addr nak
    tbl = '{32'hde5f0000, 32'hde600001, 32'hae7f0000, 32'hae800001, 32'haef00000, 32'haef70000, 32'haef80001,
            32'haeff0000, 32'hbe000011, 32'hdc000011, 32'h5e000011, 32'hae000111, 32'hde000100, 32'hde001011};
    foreach (tbl[i]) begin
      onBackup <= tbl[i][12];
      eepromBusy <= tbl[i][8];
      repeat (6) @(posedge clk_sys);
      MST.start();
      txb(tbl[i][31:24], tbl[i][4]);
      txb(tbl[i][23:16], tbl[i][0]);
      MST.stop();
    end
    onBackup <= 1'b0;
    eepromBusy <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      mfpIn <= 5'($urandom);
      repeat (3) @(posedge clk_sys);
      chk("pinOe", {7'h0, !(mfpIn[4] ? mfpIn[3] : mfpIn[2] ? mfpIn[1] : mfpIn[0])}, {7'h0, mfpOe});
      chk("pinOut", 8'h00, {7'h0, mfpOut});
      chk("sdaOut", 8'h00, {7'h0, sdaOut});
    end
    chk("pending writes", 8'h00, 8'(wq.size()));
    chk("pending reads", 8'h00, 8'(rq.size()));
    end_of_test();
  end
endmodule : rtcsl_two_wire_slave_tb
